// [hw/incl_pkg.sv]
// Shared constants and types of the inclinometer object dictionary
package incl_pkg;
  // Object indices
  localparam logic [15:0] IDX_IDENT  = 16'h1018;
  localparam logic [15:0] IDX_CYCLIC = 16'h2200;
  localparam logic [15:0] IDX_SAVE   = 16'h2300;
  localparam logic [15:0] IDX_PRE_X  = 16'h2600;
  localparam logic [15:0] IDX_PRE_Y  = 16'h2601;
  localparam logic [15:0] IDX_NODE   = 16'h3000;
  localparam logic [15:0] IDX_RATE   = 16'h3001;
  localparam logic [15:0] IDX_TERM   = 16'h3002;
  localparam logic [15:0] IDX_REC    = 16'h3022;
  localparam logic [15:0] IDX_AVG    = 16'h3100;
  localparam logic [15:0] IDX_RES    = 16'h6000;
  localparam logic [15:0] IDX_SLOPE  = 16'h6010;
  localparam logic [7:0]  IDENT_COUNT = 8'h04;
  localparam logic [31:0] SAVE_KEY    = 32'h55AAAA55;
  // Values after reset
  localparam logic [15:0] CYCLIC_RST  = 16'h0000;
  localparam logic [15:0] PRESET_RST  = 16'h0000;
  localparam logic [7:0]  NODE_RST    = 8'h00;
  localparam logic [7:0]  NODE_ID_RST = 8'h01;
  localparam logic [7:0]  RATE_RST    = 8'h03;
  localparam logic [7:0]  TERM_RST    = 8'h00;
  localparam logic [15:0] REC_RST     = 16'h0000;
  localparam logic [15:0] AVG_RST     = 16'h0064;
  localparam logic [15:0] RES_RST     = 16'h0064;
  // Accepted ranges and codes
  localparam logic [31:0] NODE_MAX = 32'h0000007E;
  localparam logic [31:0] RATE_MAX = 32'h00000007;
  localparam logic [31:0] TERM_MAX = 32'h00000001;
  localparam logic [31:0] REC_MAX  = 32'h000003E8;
  localparam logic [31:0] AVG_MAX  = 32'h000000FA;
  localparam logic signed [31:0] REC_FULL = 32'sh000003E8;
  localparam logic [15:0] RES_1DEG = 16'h03E8;
  localparam logic [15:0] RES_01   = 16'h0064;
  localparam logic [15:0] RES_001  = 16'h000A;
  // Preset limits, single axis and dual axis
  localparam logic [15:0] LIM_S_1   = 16'h0168;
  localparam logic [15:0] LIM_S_01  = 16'h0E10;
  localparam logic [15:0] LIM_S_001 = 16'h8CA0;
  localparam logic [15:0] LIM_D_1   = 16'h0050;
  localparam logic [15:0] LIM_D_01  = 16'h0320;
  localparam logic [15:0] LIM_D_001 = 16'h1F40;
  // Front end delivers hundredths of a degree
  localparam logic [15:0] DIV_1DEG = 16'h0064;
  localparam logic [15:0] DIV_01   = 16'h000A;
  localparam logic [15:0] DIV_001  = 16'h0001;
  // Abort codes
  localparam logic [31:0] AB_NONE   = 32'h00000000;
  localparam logic [31:0] AB_NO_OBJ = 32'h06020000;
  localparam logic [31:0] AB_NO_SUB = 32'h06090011;
  localparam logic [31:0] AB_RO     = 32'h06010002;
  localparam logic [31:0] AB_WO     = 32'h06010001;
  localparam logic [31:0] AB_RANGE  = 32'h06090030;
  localparam logic [31:0] AB_STATE  = 32'h08000022;

  typedef enum logic [1:0] {
    SV_IDLE  = 2'b00,
    SV_STORE = 2'b01,
    SV_RESET = 2'b11
  } incl_save_e;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] data;
  } incl_req_s;

  typedef struct packed {
    logic        valid;
    logic        abort;
    logic [31:0] data;
  } incl_rsp_s;

  typedef struct packed {
    logic [15:0] cyclic_interval;
    logic [15:0] primary_axis_preset;
    logic [15:0] lateral_axis_preset;
    logic [7:0]  node_number_minus_one;
    logic [7:0]  bit_rate_code;
    logic [7:0]  termination_switch;
    logic [15:0] recursive_filter_weight;
    logic [15:0] average_sample_count;
    logic [15:0] angle_resolution;
  } incl_params_s;

  localparam incl_params_s PARAMS_RST = '{
    cyclic_interval: CYCLIC_RST, primary_axis_preset: PRESET_RST,
    lateral_axis_preset: PRESET_RST, node_number_minus_one: NODE_RST,
    bit_rate_code: RATE_RST, termination_switch: TERM_RST,
    recursive_filter_weight: REC_RST, average_sample_count: AVG_RST,
    angle_resolution: RES_RST};

  typedef struct packed {
    logic signed [31:0] acc;
    logic [7:0]         cnt;
    logic [15:0]        value;
  } incl_smooth_s;

  typedef struct packed {
    incl_params_s params;
    logic [15:0]  x_offset;
    logic [15:0]  y_offset;
    logic [15:0]  primary_slope_value;
    logic [15:0]  lateral_slope;
    logic [7:0]   node_id;
    incl_rsp_s    rsp;
    incl_save_e   save;
    logic         store_req;
    logic         soft_reset;
  } incl_od_s;

  function automatic logic [15:0] incl_preset_lim(input logic dual,
                                                  input logic [15:0] res);
    logic [15:0] lim;
    lim = 16'h0000;
    case (res)
      RES_1DEG: lim = dual ? LIM_D_1 : LIM_S_1;
      RES_01:   lim = dual ? LIM_D_01 : LIM_S_01;
      RES_001:  lim = dual ? LIM_D_001 : LIM_S_001;
      default:  lim = 16'h0000;
    endcase
    return lim;
  endfunction : incl_preset_lim

  function automatic logic [15:0] incl_res_div(input logic [15:0] res);
    return (res == RES_1DEG) ? DIV_1DEG : (res == RES_01) ? DIV_01 : DIV_001;
  endfunction : incl_res_div

  function automatic logic [31:0] incl_sext(input logic [15:0] v);
    return {{16{v[15]}}, v};
  endfunction : incl_sext
endpackage : incl_pkg

// [hw/incl_preset_chk.sv]
// Range check of a preset value against the current resolution
`timescale 1ns/1ns
module incl_preset_chk
  import incl_pkg::*;
#(
  parameter bit DUAL_AXIS = 1'b0
) (
  // Candidate value and resolution code
  input  wire logic [15:0] value_in,
  input  wire logic [15:0] resolution_in,
  // Verdict
  output logic             ok_out
);
  logic [15:0] lim;

  always_comb begin
    lim = incl_preset_lim(DUAL_AXIS, resolution_in);
    // Dual axis is symmetric about zero, single axis runs from zero up
    if (DUAL_AXIS) begin
      ok_out = ($signed(value_in) <= $signed(lim)) &&
               ($signed(value_in) >= -$signed(lim));
    end else begin
      ok_out = (value_in <= lim);
    end
  end
endmodule : incl_preset_chk

// [hw/incl_smooth.sv]
// Block moving average followed by a recursive filter on one axis
`timescale 1ns/1ns
module incl_smooth
  import incl_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // Samples and settings
  input  wire logic        sample_valid_in,
  input  wire logic [15:0] sample_in,
  input  wire logic [15:0] avg_count_in,
  input  wire logic [15:0] weight_in,
  // Filtered value
  output logic [15:0]      value_out
);
  incl_smooth_s       st;
  incl_smooth_s       next_st;
  logic signed [31:0] sum;
  logic signed [31:0] cnt1;
  logic signed [31:0] need;
  logic signed [31:0] avg;
  logic signed [31:0] rec;

  always_comb begin
    next_st = st;
    sum  = st.acc + 32'($signed(sample_in));
    cnt1 = $signed({24'h000000, st.cnt}) + 32'sh00000001;
    // A count of zero passes every sample straight on
    need = (avg_count_in == 16'h0000) ? 32'sh00000001
                                      : $signed({16'h0000, avg_count_in});
    avg  = sum / cnt1;
    rec  = ($signed({16'h0000, weight_in}) * 32'($signed(st.value)) +
            (REC_FULL - $signed({16'h0000, weight_in})) * avg) / REC_FULL;
    if (sample_valid_in) begin
      if (cnt1 >= need) begin
        next_st.value = rec[15:0];
        next_st.acc   = 32'sh00000000;
        next_st.cnt   = 8'h00;
      end else begin
        next_st.acc = sum;
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign value_out = st.value;
endmodule : incl_smooth

// [hw/incl_object_dictionary.sv]
// Manufacturer and profile object dictionary entries of the inclinometer
`timescale 1ns/1ns
// Notes on behaviour
// - Identity entry: count plus four read-only codes
// - Cyclic interval drives both transmit event timers
// - At boot, mismatched cyclic interval takes event timer
// - Key write stores parameters, then resets device
// - Primary preset sets primary axis value
// - Out-of-range preset for resolution gets error
// - Dual axis: lateral preset sets lateral axis
// - Effective node number is stored value plus one
// - Bit-rate code 0..7 selects bus rate
// - Termination entry: one enables, zero disables
// - Recursive filter weights history by setting/1000
// - Moving average over 0..250 samples, default 100
// - Resolution codes 1000, 100, 10 select step
// - Read-only slope entry returns primary axis
// - Slope times resolution gives thousandths of a degree
module incl_object_dictionary
  import incl_pkg::*;
#(
  parameter bit          DUAL_AXIS     = 1'b0,
  parameter logic [31:0] MAKER_CODE    = 32'h00000ABC, // Arbitrary value
  parameter logic [31:0] PART_CODE     = 32'h00001234, // Arbitrary value
  parameter logic [31:0] REVISION_CODE = 32'h00000001, // Arbitrary value
  parameter logic [31:0] UNIT_SERIAL   = 32'h00000000  // Arbitrary value
) (
  // Clock and reset
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  // Object dictionary access
  input  wire incl_req_s     od_req_in,
  output incl_rsp_s          od_rsp_out,
  // Sensing front end
  input  wire logic          sample_valid_in,
  input  wire logic [15:0]   x_sample_in,
  input  wire logic [15:0]   y_sample_in,
  // Non-volatile parameter store
  input  wire incl_params_s  param_restore_in,
  input  wire logic          restore_valid_in,
  input  wire logic [15:0]   event_timer_in,
  input  wire logic          store_done_in,
  output logic               store_req_out,
  output logic               soft_reset_out,
  output incl_params_s       param_image_out,
  // Configuration and readouts
  output logic [15:0]        cyclic_interval_out,
  output logic [7:0]         node_id_out,
  output logic [7:0]         bit_rate_code_out,
  output logic               termination_en_out,
  output logic [15:0]        lateral_slope_out
);
  incl_od_s    st;
  incl_od_s    next_st;
  logic [15:0] filt_x;
  logic [15:0] filt_y;
  logic [15:0] scaled_x;
  logic [15:0] scaled_y;
  logic [15:0] div;
  logic [15:0] req_d16;
  logic        x_ok;
  logic        y_ok;
  logic        sub_bad;
  logic        wr;
  logic        req_wr;
  logic        req_rd;
  logic [31:0] item_err;
  logic [31:0] rdata;
  logic [15:0] primary_slope;

  assign req_d16 = od_req_in.data[15:0];

  incl_smooth u_smooth_x (
    .sys_clk_in      (sys_clk_in),
    .rst_in          (rst_in),
    .sample_valid_in (sample_valid_in),
    .sample_in       (x_sample_in),
    .avg_count_in    (st.params.average_sample_count),
    .weight_in       (st.params.recursive_filter_weight),
    .value_out       (filt_x)
  );

  incl_smooth u_smooth_y (
    .sys_clk_in      (sys_clk_in),
    .rst_in          (rst_in),
    .sample_valid_in (sample_valid_in),
    .sample_in       (y_sample_in),
    .avg_count_in    (st.params.average_sample_count),
    .weight_in       (st.params.recursive_filter_weight),
    .value_out       (filt_y)
  );

  incl_preset_chk #(.DUAL_AXIS(DUAL_AXIS)) u_chk_x (
    .value_in      (req_d16),
    .resolution_in (st.params.angle_resolution),
    .ok_out        (x_ok)
  );

  incl_preset_chk #(.DUAL_AXIS(DUAL_AXIS)) u_chk_y (
    .value_in      (req_d16),
    .resolution_in (st.params.angle_resolution),
    .ok_out        (y_ok)
  );

  // Hundredths of a degree scaled down to steps of the selected resolution
  always_comb begin
    div      = incl_res_div(st.params.angle_resolution);
    scaled_x = 16'($signed(filt_x) / $signed({1'b0, div}));
    scaled_y = 16'($signed(filt_y) / $signed({1'b0, div}));
  end

  always_comb begin
    next_st            = st;
    next_st.rsp        = '0;
    next_st.store_req  = 1'b0;
    next_st.soft_reset = 1'b0;
    item_err           = AB_NONE;
    rdata              = 32'h00000000;
    sub_bad = (od_req_in.index == IDX_IDENT) ? (od_req_in.sub > IDENT_COUNT)
                                              : (od_req_in.sub != 8'h00);
    wr = od_req_in.valid && od_req_in.write && !sub_bad;

    unique case (st.save)
      SV_IDLE:  next_st.save = SV_IDLE;
      SV_STORE: begin
        if (store_done_in) begin
          next_st.save       = SV_RESET;
          next_st.soft_reset = 1'b1;
        end
      end
      SV_RESET: next_st.save = SV_IDLE;
      default:  next_st.save = SV_IDLE;
    endcase

    case (od_req_in.index)
      IDX_IDENT: begin
        if (od_req_in.write) item_err = AB_RO;
        case (od_req_in.sub)
          8'h00:   rdata = {24'h000000, IDENT_COUNT};
          8'h01:   rdata = MAKER_CODE;
          8'h02:   rdata = PART_CODE;
          8'h03:   rdata = REVISION_CODE;
          default: rdata = UNIT_SERIAL;
        endcase
      end
      IDX_CYCLIC: begin
        rdata = {16'h0000, st.params.cyclic_interval};
        if (wr) next_st.params.cyclic_interval = req_d16;
      end
      IDX_SAVE: begin
        if (!od_req_in.write) begin
          item_err = AB_WO;
        end else if (od_req_in.data != SAVE_KEY) begin
          item_err = AB_RANGE;
        end else if (st.save != SV_IDLE) begin
          item_err = AB_STATE;
        end else if (wr) begin
          next_st.save      = SV_STORE;
          next_st.store_req = 1'b1;
        end
      end
      IDX_PRE_X: begin
        rdata = incl_sext(st.params.primary_axis_preset);
        if (od_req_in.write && !x_ok) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.primary_axis_preset = req_d16;
          next_st.x_offset = req_d16 - scaled_x;
        end
      end
      IDX_PRE_Y: begin
        rdata = incl_sext(st.params.lateral_axis_preset);
        if (!DUAL_AXIS) begin
          item_err = AB_NO_OBJ;
        end else if (od_req_in.write && !y_ok) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.lateral_axis_preset = req_d16;
          next_st.y_offset = req_d16 - scaled_y;
        end
      end
      IDX_NODE: begin
        rdata = {24'h000000, st.params.node_number_minus_one};
        if (od_req_in.write && od_req_in.data > NODE_MAX) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.node_number_minus_one = od_req_in.data[7:0];
        end
      end
      IDX_RATE: begin
        rdata = {24'h000000, st.params.bit_rate_code};
        if (od_req_in.write && od_req_in.data > RATE_MAX) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.bit_rate_code = od_req_in.data[7:0];
        end
      end
      IDX_TERM: begin
        rdata = {24'h000000, st.params.termination_switch};
        if (od_req_in.write && od_req_in.data > TERM_MAX) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.termination_switch = od_req_in.data[7:0];
        end
      end
      IDX_REC: begin
        rdata = {16'h0000, st.params.recursive_filter_weight};
        if (od_req_in.write && od_req_in.data > REC_MAX) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.recursive_filter_weight = req_d16;
        end
      end
      IDX_AVG: begin
        rdata = {16'h0000, st.params.average_sample_count};
        if (od_req_in.write && od_req_in.data > AVG_MAX) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.average_sample_count = req_d16;
        end
      end
      IDX_RES: begin
        rdata = {16'h0000, st.params.angle_resolution};
        if (od_req_in.write && od_req_in.data != {16'h0000, RES_1DEG} &&
            od_req_in.data != {16'h0000, RES_01} &&
            od_req_in.data != {16'h0000, RES_001}) begin
          item_err = AB_RANGE;
        end else if (wr) begin
          next_st.params.angle_resolution = req_d16;
        end
      end
      IDX_SLOPE: begin
        rdata = incl_sext(st.primary_slope_value);
        if (od_req_in.write) item_err = AB_RO;
      end
      default: item_err = AB_NO_OBJ;
    endcase

    if (od_req_in.valid) begin
      next_st.rsp.valid = 1'b1;
      if (item_err == AB_NO_OBJ || (item_err != AB_NONE && !sub_bad)) begin
        next_st.rsp.abort = 1'b1;
        next_st.rsp.data  = item_err;
      end else if (sub_bad) begin
        next_st.rsp.abort = 1'b1;
        next_st.rsp.data  = AB_NO_SUB;
      end else if (!od_req_in.write) begin
        next_st.rsp.data = rdata;
      end
    end

    next_st.primary_slope_value = scaled_x + st.x_offset;
    next_st.lateral_slope       = scaled_y + st.y_offset;

    // Restored image wins over a write in the same cycle
    if (restore_valid_in) begin
      next_st.params = param_restore_in;
      if (param_restore_in.cyclic_interval != event_timer_in) begin
        next_st.params.cyclic_interval = event_timer_in;
      end
      next_st.x_offset = param_restore_in.primary_axis_preset - scaled_x;
      next_st.y_offset = param_restore_in.lateral_axis_preset - scaled_y;
    end
    next_st.node_id = next_st.params.node_number_minus_one + 8'h01;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st         <= '0;
      st.params  <= PARAMS_RST;
      st.node_id <= NODE_ID_RST;
    end else begin
      st <= next_st;
    end
  end

  assign od_rsp_out          = st.rsp;
  assign store_req_out       = st.store_req;
  assign soft_reset_out      = st.soft_reset;
  assign param_image_out     = st.params;
  assign cyclic_interval_out = st.params.cyclic_interval;
  assign node_id_out         = st.node_id;
  assign bit_rate_code_out   = st.params.bit_rate_code;
  assign termination_en_out  = st.params.termination_switch[0];
  assign lateral_slope_out   = st.lateral_slope;
  assign primary_slope       = st.primary_slope_value;

  // Checks
  assign req_wr = od_req_in.valid && od_req_in.write && !restore_valid_in &&
                  od_req_in.sub == 8'h00;
  assign req_rd = od_req_in.valid && !od_req_in.write &&
                  od_req_in.sub == 8'h00;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  property p_ident_count;
    req_rd && od_req_in.index == IDX_IDENT |=>
      od_rsp_out.valid && !od_rsp_out.abort && od_rsp_out.data == 32'h4;
  endproperty
  a_ident_count: assert property (p_ident_count)
    else $error("identity count not four");

  property p_cyclic_wr;
    req_wr && od_req_in.index == IDX_CYCLIC |=>
      cyclic_interval_out == $past(req_d16);
  endproperty
  a_cyclic_wr: assert property (p_cyclic_wr)
    else $error("cyclic interval not taken");

  property p_boot_copy;
    restore_valid_in && param_restore_in.cyclic_interval != event_timer_in
      |=> cyclic_interval_out == $past(event_timer_in);
  endproperty
  a_boot_copy: assert property (p_boot_copy)
    else $error("event timer not copied at boot");

  property p_save_seq;
    req_wr && od_req_in.index == IDX_SAVE && od_req_in.data == SAVE_KEY &&
      st.save == SV_IDLE |=> store_req_out ##1 !store_req_out;
  endproperty
  a_save_seq: assert property (p_save_seq)
    else $error("store request not pulsed");

  property p_reset_after_store;
    st.save == SV_STORE && store_done_in |=>
      soft_reset_out ##1 (!soft_reset_out && st.save == SV_IDLE);
  endproperty
  a_reset_after_store: assert property (p_reset_after_store)
    else $error("reset not issued after store");

  property p_preset_ok;
    req_wr && od_req_in.index == IDX_PRE_X && x_ok |=> !od_rsp_out.abort &&
      param_image_out.primary_axis_preset == $past(req_d16);
  endproperty
  a_preset_ok: assert property (p_preset_ok)
    else $error("valid preset not stored");

  property p_preset_range;
    req_wr && od_req_in.index == IDX_PRE_X && !x_ok |=>
      od_rsp_out.abort && od_rsp_out.data == AB_RANGE &&
      $stable(param_image_out.primary_axis_preset);
  endproperty
  a_preset_range: assert property (p_preset_range)
    else $error("out of range preset accepted");

  property p_node_plus_one;
    node_id_out == param_image_out.node_number_minus_one + 8'h01;
  endproperty
  a_node_plus_one: assert property (p_node_plus_one)
    else $error("node number not stored value plus one");

  property p_rate_range;
    req_wr && od_req_in.index == IDX_RATE && od_req_in.data > RATE_MAX |=>
      od_rsp_out.abort && $stable(bit_rate_code_out);
  endproperty
  a_rate_range: assert property (p_rate_range)
    else $error("bad bit rate code accepted");

  property p_term_on;
    req_wr && od_req_in.index == IDX_TERM && od_req_in.data == 32'h1 |=>
      termination_en_out;
  endproperty
  a_term_on: assert property (p_term_on)
    else $error("termination not enabled");

  property p_filter_range;
    req_wr && od_req_in.index == IDX_REC && od_req_in.data > REC_MAX |=>
      od_rsp_out.abort && $stable(param_image_out.recursive_filter_weight);
  endproperty
  a_filter_range: assert property (p_filter_range)
    else $error("bad filter weight accepted");

  property p_slope_ro;
    req_wr && od_req_in.index == IDX_SLOPE |=>
      od_rsp_out.abort && od_rsp_out.data == AB_RO;
  endproperty
  a_slope_ro: assert property (p_slope_ro)
    else $error("slope write not refused");

  property p_slope_rd;
    req_rd && od_req_in.index == IDX_SLOPE |=>
      od_rsp_out.data == incl_sext($past(primary_slope));
  endproperty
  a_slope_rd: assert property (p_slope_rd)
    else $error("slope readout mismatch");

  c_save_cycle: cover property (store_req_out ##[1:20] soft_reset_out);
  c_preset_set: cover property (
    req_wr && od_req_in.index == IDX_PRE_X && x_ok);
  c_boot_mismatch: cover property (
    restore_valid_in && param_restore_in.cyclic_interval != event_timer_in);
  c_range_abort: cover property (
    od_rsp_out.abort && od_rsp_out.data == AB_RANGE);
endmodule : incl_object_dictionary

// [tb/incl_master.sv]
// Master model that issues object dictionary requests
`timescale 1ns/1ns
module incl_master
  import incl_pkg::*;
(
  // Clock
  input  wire logic      sys_clk_in,
  // Requests and answers
  output incl_req_s      od_req_out,
  input  wire incl_rsp_s od_rsp_in
);
  initial od_req_out = '0;
  // Request held for one edge; data inverted once released
  task automatic xfer(input logic w, input logic [15:0] i,
                      input logic [7:0] s, input logic [31:0] d,
                      output incl_rsp_s r);
    @(posedge sys_clk_in);
    od_req_out <= '{1'b1, w, i, s, d};
    @(posedge sys_clk_in);
    od_req_out.valid <= 1'b0;
    od_req_out.data  <= ~d;
    @(posedge sys_clk_in);
    r = od_rsp_in;
  endtask : xfer
endmodule : incl_master

// [tb/tb.sv]
// Self-checking bench of the inclinometer object dictionary
`timescale 1ns/1ns
module tb;
  import incl_pkg::*;
  localparam logic [31:0] MK = 32'h00000A5A; // Arbitrary value
  localparam logic [31:0] PC = 32'h0000C3C3; // Arbitrary value
  logic         sys_clk_in = 1'b0;
  logic         rst_in     = 1'b1;
  incl_req_s    od_req;
  incl_rsp_s    od_rsp;
  incl_params_s img        = PARAMS_RST;
  logic         rv         = 1'b0;
  logic [15:0]  evt        = 16'h0000;
  logic         done       = 1'b0;
  logic         sv         = 1'b0;
  logic [15:0]  xs         = 16'h0000;
  logic [15:0]  lat;
  incl_params_s pimg;
  logic         st, sr, term;
  logic [15:0]  cyc;
  logic [7:0]   nid, rate;
  int           n_errors = 0, n_tests = 0, cycles = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  incl_object_dictionary #(.MAKER_CODE(MK), .PART_CODE(PC))
    incl_object_dictionary_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .od_req_in(od_req), .od_rsp_out(od_rsp), .sample_valid_in(sv),
    .x_sample_in(xs), .y_sample_in(xs), .param_restore_in(img),
    .restore_valid_in(rv), .event_timer_in(evt), .store_done_in(done),
    .store_req_out(st), .soft_reset_out(sr), .param_image_out(pimg),
    .cyclic_interval_out(cyc), .node_id_out(nid), .bit_rate_code_out(rate),
    .termination_en_out(term), .lateral_slope_out(lat));
  incl_master incl_master_inst (.sys_clk_in(sys_clk_in),
    .od_req_out(od_req), .od_rsp_in(od_rsp));
  task automatic check(input string what, input logic [32:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One access, abort flag and data compared together
  task automatic acc(input logic w, input logic [15:0] i,
                     input logic [31:0] d, input logic [32:0] e);
    incl_rsp_s r;
    incl_master_inst.xfer(w, i, 8'h00, d, r);
    check("rsp valid", r.valid, 33'h1);
    check("response", {r.abort, r.data}, e);
  endtask : acc
  task automatic t_ident;
    incl_rsp_s r;
    incl_master_inst.xfer(1'b0, IDX_IDENT, 8'h01, 32'h0, r);
    check("maker", {r.abort, r.data}, {1'b0, MK});
    incl_master_inst.xfer(1'b0, IDX_IDENT, 8'h02, 32'h0, r);
    check("part", {r.abort, r.data}, {1'b0, PC});
    acc(1'b0, IDX_IDENT, 32'h0, {25'h0, IDENT_COUNT});
    acc(1'b1, IDX_IDENT, 32'h9, {1'b1, AB_RO});
    acc(1'b1, IDX_SLOPE, 32'h9, {1'b1, AB_RO});
    acc(1'b0, IDX_SAVE, 32'h0, {1'b1, AB_WO});
  endtask : t_ident
  task automatic t_cfg;
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, IDX_RATE, c, 33'h0);
      check("rate", rate, c);
    end
    acc(1'b1, IDX_RATE, 32'h8, {1'b1, AB_RANGE});
    check("rate kept", rate, 33'h7);
    acc(1'b1, IDX_NODE, 32'h1F, 33'h0);
    check("node", nid, 33'h20);
    acc(1'b1, IDX_TERM, 32'h1, 33'h0);
    check("term on", term, 33'h1);
    acc(1'b1, IDX_TERM, 32'h0, 33'h0);
    check("term off", term, 33'h0);
  endtask : t_cfg
  task automatic t_filt;
    acc(1'b1, IDX_REC, REC_MAX, 33'h0);
    acc(1'b1, IDX_REC, REC_MAX + 1, {1'b1, AB_RANGE});
    acc(1'b0, IDX_REC, 32'h0, {1'b0, REC_MAX});
    acc(1'b1, IDX_AVG, AVG_MAX + 1, {1'b1, AB_RANGE});
    acc(1'b0, IDX_AVG, 32'h0, {17'h0, AVG_RST});
  endtask : t_filt
  task automatic t_preset;
    acc(1'b1, IDX_RES, 32'h65, {1'b1, AB_RANGE});
    acc(1'b1, IDX_RES, 32'h0A, 33'h0);
    acc(1'b1, IDX_PRE_X, 32'h8CA0, 33'h0);
    acc(1'b1, IDX_RES, 32'h3E8, 33'h0);
    acc(1'b1, IDX_PRE_X, 32'h169, {1'b1, AB_RANGE});
    acc(1'b1, IDX_PRE_X, 32'h168, 33'h0);
    acc(1'b0, IDX_SLOPE, 32'h0, 33'h168);
    acc(1'b0, IDX_PRE_Y, 32'h0, {1'b1, AB_NO_OBJ});
  endtask : t_preset
  task automatic t_boot;
    img.cyclic_interval <= 16'h0005;
    evt <= 16'h0009;
    rv  <= 1'b1;
    @(posedge sys_clk_in);
    rv  <= 1'b0;
    @(posedge sys_clk_in);
    check("boot cyclic", cyc, 33'h9);
    acc(1'b1, IDX_CYCLIC, 32'h1234, 33'h0);
    check("cyclic", cyc, 33'h1234);
  endtask : t_boot
  // Two equal samples on both axes, one per clock
  task automatic feed(input logic [15:0] v);
    sv <= 1'b1;
    xs <= v;
    repeat (2) @(posedge sys_clk_in);
    sv <= 1'b0;
  endtask : feed
  task automatic t_avg;
    acc(1'b1, IDX_AVG, 32'h2, 33'h0);
    feed(16'h00C8);
    acc(1'b0, IDX_SLOPE, 32'h0, 33'h14);
    check("lateral", lat, 33'h14);
    acc(1'b1, IDX_REC, 32'h1F4, 33'h0);
    feed(16'h0000);
    acc(1'b0, IDX_SLOPE, 32'h0, 33'h0A);
  endtask : t_avg
  task automatic t_save;
    acc(1'b1, IDX_SAVE, SAVE_KEY, 33'h0);
    check("store", st, 33'h1);
    check("image", pimg.cyclic_interval, 33'h1234);
    acc(1'b1, IDX_SAVE, SAVE_KEY, {1'b1, AB_STATE});
    @(posedge sys_clk_in) done <= 1'b1;
    @(posedge sys_clk_in) done <= 1'b0;
    @(posedge sys_clk_in);
    check("reset", sr, 33'h1);
  endtask : t_save
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_ident();
    t_cfg();
    t_filt();
    t_preset();
    t_boot();
    t_avg();
    t_save();
    final_report();
  end
endmodule : tb
